// ---- hdl/sdmr_core.sv ----
`timescale 1ns/10ps
module sdmr_core
   import sdmr_pkg::*;
#(
   parameter int CWL = 5,
   parameter int TRP_CK = 5
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Memory link pins
   input wire logic i_ck,
   input wire sdmr_pins_t i_pins,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // Burst datapath
   output logic o_dq_dqs_oe,
   output logic o_rd_beat,
   output logic o_wr_beat,
   output logic [2:0] o_beat_col,
   output logic o_wr_start,
   // DLL control
   output logic o_dll_reset,
   output logic o_dll_freeze_pd
);
   localparam int DLL_WAIT_MAX = 200;

   sdmr_state_t st;
   sdmr_state_t nx;
   logic ck_rise;
   logic ck_edge;
   logic cmd_ok;
   logic is_mrs;
   logic is_rd;
   logic is_wr;
   logic mrs0_ev;
   logic mrs1_ev;
   logic otf_chop;
   logic [5:0] cl_c;
   logic [5:0] al_c;
   logic [5:0] rl_c;
   logic [5:0] wl_c;
   logic [5:0] dal_c;
   logic [2:0] rtt;
   logic rtt_bad;
   logic [2:0] beat_sel;
   logic [2:0] col;
   logic in_wr;
   logic [31:0] stat;

   // ==========================================
   // Link sampling and command decode
   assign ck_rise = st.ck_s & ~st.ck_d;
   assign ck_edge = st.ck_s ^ st.ck_d;
   assign cmd_ok = st.ctrl_en & ~st.pin_s.cs_n & ck_rise;
   assign is_mrs = cmd_ok & ~st.pin_s.ras_n & ~st.pin_s.cas_n
                   & ~st.pin_s.we_n;
   assign is_rd = cmd_ok & st.pin_s.ras_n & ~st.pin_s.cas_n
                  & st.pin_s.we_n;
   assign is_wr = cmd_ok & st.pin_s.ras_n & ~st.pin_s.cas_n
                  & ~st.pin_s.we_n;
   // all bank bits low selects mode zero
   assign mrs0_ev = is_mrs & (st.pin_s.ba == 3'h0);
   // only bank bit 0 high selects mode one
   assign mrs1_ev = is_mrs & (st.pin_s.ba == 3'h1);

   // ==========================================
   // Mode decode
   // CAS delay code from bits 2, 6, 5, 4
   assign cl_c = CL_BASE + {2'h0, st.mr0[2], st.mr0[6:4]};

   always_comb begin
      case (st.mr1[MR1_AL_LO +: 2])
         AL_CL1: al_c = cl_c - 6'h01;
         AL_CL2: al_c = cl_c - 6'h02;
         default: al_c = 6'h00;
      endcase
   end
   assign rl_c = al_c + cl_c;
   assign wl_c = al_c + 6'(CWL);

   assign dal_c = WR_BASE + {3'h0, st.mr0[MR0_WR_LO +: 3]}
                  + 6'(TRP_CK);

   // on-the-fly mode follows the chop pin
   assign otf_chop = st.mr0[1:0] == BL_OTF;

   // Termination flagged when not a legal value, outside output-off leveling
   assign rtt = {st.mr1[9], st.mr1[6], st.mr1[2]};
   assign rtt_bad = (rtt != RTT_OFF) && (rtt != RTT_Q4)
                    && (rtt != RTT_Q2) && (rtt != RTT_Q6)
                    && !(st.mr1[MR1_WLVL] && st.mr1[MR1_QOFF]);

   // ==========================================
   // Beat ordering
   assign in_wr = (st.fsm == S_WWAIT) || (st.fsm == S_WBURST);
   assign beat_sel = ((st.fsm == S_RBURST) || (st.fsm == S_WBURST))
                     ? st.beat + 3'h1 : 3'h0;

   sdmr_beat_order u_order (
      .i_start(st.col0),
      .i_beat(beat_sel),
      .i_interleave(st.ilv),
      .i_write(in_wr),
      .i_chop(st.chop),
      .o_col(col)
   );

   // ==========================================
   // Status word
   always_comb begin
      stat = 32'h0000_0000;
      stat[ST_RL_LO +: 6] = st.rl;
      stat[ST_DAL_LO +: 6] = st.tdal;
      stat[ST_DLL_BUSY] = st.dll_busy;
      stat[ST_TEST] = st.mr0[MR0_TM];
      stat[ST_SLOW_PD] = ~st.mr0[MR0_PPD];
      stat[ST_RTT_BAD] = rtt_bad;
      stat[ST_AL_RSV] = &st.mr1[MR1_AL_LO +: 2];
   end

   // ==========================================
   // Next state
   always_comb begin
      nx = st;
      nx.ck_m = i_ck;
      nx.ck_s = st.ck_m;
      nx.ck_d = st.ck_s;
      nx.pin_m = i_pins;
      nx.pin_s = st.pin_m;
      nx.rd_beat = 1'b0;
      nx.wr_beat = 1'b0;
      nx.wr_start = 1'b0;
      nx.dll_pulse = 1'b0;
      nx.rl = rl_c;
      nx.tdal = dal_c;

      // APB: answer one cycle after setup
      nx.pready = i_psel & ~i_penable;
      if (i_psel && !i_penable) begin
         nx.pslverr = 1'b0;
         case (i_paddr)
            ADDR_CTRL: nx.prdata = {31'h0000_0000, st.ctrl_en};
            ADDR_MR0: nx.prdata = {18'h00000, st.mr0};
            ADDR_MR1: nx.prdata = {18'h00000, st.mr1};
            ADDR_STAT: nx.prdata = stat;
            default: begin
               nx.prdata = 32'h0000_0000;
               nx.pslverr = 1'b1;
            end
         endcase
      end
      if (i_psel && i_penable && st.pready && i_pwrite
          && i_paddr == ADDR_CTRL) begin
         nx.ctrl_en = i_pwdata[CTRL_EN];
      end

      if (st.dll_busy && ck_rise) begin
         nx.dll_cnt = st.dll_cnt - 8'h01;
         if (st.dll_cnt == 8'h01) begin
            nx.dll_busy = 1'b0;
            nx.mr0[MR0_DLLR] = 1'b0;
         end
      end

      // latch every field at the mode set
      if (mrs0_ev) begin
         nx.mr0 = st.pin_s.addr;
         if (st.pin_s.addr[MR0_DLLR]) begin
            nx.dll_busy = 1'b1;
            nx.dll_cnt = DLL_RST_CK;
            nx.dll_pulse = 1'b1;
         end
      end
      if (mrs1_ev) begin
         nx.mr1 = st.pin_s.addr;
      end

      case (st.fsm)
         S_IDLE: begin
            if (is_rd || is_wr) begin
               nx.col0 = st.pin_s.addr[2:0];
               nx.ilv = st.mr0[MR0_BT];
               nx.bc4fix = st.mr0[1:0] == BL_FIX4;
               // chop pin sampled with the command
               nx.chop = otf_chop ? st.pin_s.addr[ADDR_CHOP]
                                  : st.mr0[1:0] == BL_FIX4;
               nx.fsm = is_rd ? S_RWAIT : S_WWAIT;
               nx.cnt = is_rd ? rl_c : wl_c;
            end
         end
         S_RWAIT: begin
            if (ck_rise) begin
               nx.cnt = st.cnt - 6'h01;
               if (st.cnt == 6'h01) begin
                  nx.fsm = S_RBURST;
                  nx.beat = 3'h0;
                  nx.beat_col = col;
                  nx.rd_beat = 1'b1;
                  nx.dq_oe = ~st.mr1[MR1_QOFF];
               end
            end
         end
         S_RBURST: begin
            if (ck_edge) begin
               if (st.beat == BEAT_LAST) begin
                  nx.fsm = S_IDLE;
                  nx.dq_oe = 1'b0;
               end else begin
                  nx.beat = beat_sel;
                  nx.beat_col = col;
                  // chop read floats the last four slots
                  nx.rd_beat = ~(st.chop & beat_sel[2]);
                  nx.dq_oe = ~(st.chop & beat_sel[2])
                             & ~st.mr1[MR1_QOFF];
               end
            end
         end
         S_WWAIT: begin
            if (ck_rise) begin
               nx.cnt = st.cnt - 6'h01;
               if (st.cnt == 6'h01) begin
                  nx.fsm = S_WBURST;
                  nx.beat = 3'h0;
                  nx.beat_col = col;
                  nx.wr_beat = 1'b1;
               end
            end
         end
         S_WBURST: begin
            if (ck_edge) begin
               if (st.beat == BEAT_LAST) begin
                  nx.fsm = S_IDLE;
                  // on-the-fly chop starts like eight beats
                  nx.wr_start = ~st.bc4fix;
               end else begin
                  nx.beat = beat_sel;
                  nx.beat_col = col;
                  nx.wr_beat = ~(st.chop & beat_sel[2]);
                  // fixed chop starts two clocks early
                  nx.wr_start = st.bc4fix & (beat_sel == BEAT_HALF);
               end
            end
         end
         default: begin
            nx.fsm = S_IDLE;
         end
      endcase

      // slow exit freezes the DLL in power-down
      nx.dll_frz = ~nx.mr0[MR0_PPD];

      if (!i_rst_n) begin
         nx = '0;
         nx.fsm = S_IDLE;
         nx.ctrl_en = CTRL_EN_RST;
         // Mode zero clears to slow exit
         nx.dll_frz = 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      st <= nx;
   end

   // ==========================================
   // Outputs
   assign o_pready = st.pready;
   assign o_prdata = st.prdata;
   assign o_pslverr = st.pslverr;
   assign o_dq_dqs_oe = st.dq_oe;
   assign o_rd_beat = st.rd_beat;
   assign o_wr_beat = st.wr_beat;
   assign o_beat_col = st.beat_col;
   assign o_wr_start = st.wr_start;
   assign o_dll_reset = st.dll_pulse;
   assign o_dll_freeze_pd = st.dll_frz;

   // ==========================================
   // Assertions
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   a_mr0_latch: assert property (mrs0_ev |=>
      st.mr0[7:0] == $past(st.pin_s.addr[7:0]))
      else $error("mode zero not latched");
   a_mr1_latch: assert property (mrs1_ev |=>
      st.mr1 == $past(st.pin_s.addr))
      else $error("mode one not latched");
   a_chop_hiz: assert property (
      st.fsm == S_RBURST && st.chop && st.beat[2] |-> !st.dq_oe)
      else $error("driver on in chopped slot");
   a_dll_clear: assert property (
      $rose(st.dll_busy) |-> ##[1:DLL_WAIT_MAX] !st.mr0[MR0_DLLR])
      else $error("dll reset bit stuck");
   a_bc4_early: assert property (
      st.wr_start && st.bc4fix |-> st.fsm == S_WBURST
      && st.beat == BEAT_HALF)
      else $error("fixed chop write start late");
   a_otf_late: assert property (
      st.wr_start && !st.bc4fix |-> st.fsm == S_IDLE
      && $past(st.fsm) == S_WBURST)
      else $error("eight beat write start misplaced");
   a_read_delay: assert property (
      st.fsm == S_RWAIT && $past(st.fsm) == S_IDLE
      |-> st.cnt == $past(rl_c))
      else $error("read delay wrong");
   a_write_col: assert property (
      st.wr_beat |-> st.beat_col[1:0] == st.beat[1:0]
      && st.beat_col[2] == (st.chop ? st.col0[2] : st.beat[2]))
      else $error("write column wrong");
   a_seq_order: assert property (
      st.rd_beat && !st.ilv |->
      st.beat_col[1:0] == st.col0[1:0] + st.beat[1:0])
      else $error("sequential order wrong");
   a_ilv_order: assert property (
      st.rd_beat && st.ilv |-> st.beat_col == (st.col0 ^ st.beat))
      else $error("interleaved order wrong");
   a_chop_pin: assert property (
      (is_rd || is_wr) && st.fsm == S_IDLE && otf_chop
      |=> st.chop == $past(st.pin_s.addr[ADDR_CHOP]))
      else $error("chop pin not sampled");

   c_read_bl8: cover property (st.rd_beat && !st.chop
      && st.beat == BEAT_LAST);
   c_read_chop: cover property (st.fsm == S_RBURST && st.chop
      && st.beat == BEAT_LAST);
   c_write_early: cover property (st.wr_start && st.bc4fix);
   c_dll_reset: cover property ($fell(st.dll_busy));
endmodule

// ---- hdl/sdmr_pkg.sv ----
package sdmr_pkg;
   // ==========================================
   // Register map
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_MR0 = 12'h004;
   localparam logic [11:0] ADDR_MR1 = 12'h008;
   localparam logic [11:0] ADDR_STAT = 12'h00C;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int CTRL_EN = 0;
   // ==========================================
   // Mode register fields
   localparam int MR0_BT = 3;
   localparam int MR0_TM = 7;
   localparam int MR0_DLLR = 8;
   localparam int MR0_WR_LO = 9;
   localparam int MR0_PPD = 12;
   localparam int MR1_AL_LO = 3;
   localparam int MR1_WLVL = 7;
   localparam int MR1_QOFF = 12;
   localparam int ADDR_CHOP = 12;
   localparam logic [1:0] BL_FIX8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_FIX4 = 2'h2;
   localparam logic [1:0] AL_OFF = 2'h0;
   localparam logic [1:0] AL_CL1 = 2'h1;
   localparam logic [1:0] AL_CL2 = 2'h2;
   localparam logic [2:0] RTT_OFF = 3'h0;
   localparam logic [2:0] RTT_Q4 = 3'h1;
   localparam logic [2:0] RTT_Q2 = 3'h2;
   localparam logic [2:0] RTT_Q6 = 3'h3;
   // ==========================================
   // Counts, in link clock cycles or beats
   localparam logic [5:0] CL_BASE = 6'h04;
   localparam logic [5:0] WR_BASE = 6'h05;
   localparam logic [7:0] DLL_RST_CK = 8'h10;
   localparam logic [2:0] BEAT_HALF = 3'h4;
   localparam logic [2:0] BEAT_LAST = 3'h7;
   // ==========================================
   // Status register fields
   localparam int ST_RL_LO = 0;
   localparam int ST_DAL_LO = 8;
   localparam int ST_DLL_BUSY = 16;
   localparam int ST_TEST = 17;
   localparam int ST_SLOW_PD = 18;
   localparam int ST_RTT_BAD = 19;
   localparam int ST_AL_RSV = 20;
   // ==========================================
   // Types
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [2:0] ba;
      logic [13:0] addr;
   } sdmr_pins_t;

   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_RWAIT = 5'h02,
      S_RBURST = 5'h04,
      S_WWAIT = 5'h08,
      S_WBURST = 5'h10
   } sdmr_fsm_t;

   typedef struct packed {
      logic ck_m;
      logic ck_s;
      logic ck_d;
      sdmr_pins_t pin_m;
      sdmr_pins_t pin_s;
      logic ctrl_en;
      logic [13:0] mr0;
      logic [13:0] mr1;
      sdmr_fsm_t fsm;
      logic [5:0] cnt;
      logic [2:0] beat;
      logic [2:0] col0;
      logic chop;
      logic ilv;
      logic bc4fix;
      logic dll_busy;
      logic [7:0] dll_cnt;
      logic [5:0] rl;
      logic [5:0] tdal;
      logic dq_oe;
      logic rd_beat;
      logic wr_beat;
      logic wr_start;
      logic dll_pulse;
      logic dll_frz;
      logic [2:0] beat_col;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } sdmr_state_t;
endpackage

// ---- hdl/sdmr_beat_order.sv ----
`timescale 1ns/10ps
module sdmr_beat_order
   import sdmr_pkg::*;
(
   // Burst description
   input wire logic [2:0] i_start,
   input wire logic [2:0] i_beat,
   input wire logic i_interleave,
   input wire logic i_write,
   input wire logic i_chop,
   // Column of this beat
   output logic [2:0] o_col
);
   logic [1:0] nib;

   assign nib = i_start[1:0] + i_beat[1:0];

   always_comb begin
      if (i_write) begin
         o_col = i_chop ? {i_start[2], i_beat[1:0]} : i_beat;
      end else if (i_interleave) begin
         o_col = i_start ^ i_beat;
      end else if (i_chop) begin
         o_col = {i_start[2], nib};
      end else begin
         o_col = {i_start[2] ^ i_beat[2], nib};
      end
   end
endmodule

// ---- testbench/sdmr_ctrl_model.sv ----
`timescale 1ns/10ps
module sdmr_ctrl_model
   import sdmr_pkg::*;
#(
   parameter int DLL_LOCK_CK = 20,
   parameter logic [2:0] WR_MIN_CODE = 3'h0
) (
   // Link to the device
   output logic o_ck,
   output sdmr_pins_t o_pins
);
   localparam time CK_HALF = 160;
   logic ck = 1'b0;
   sdmr_pins_t pins = {1'b1, 20'h00000};
   time cmd_time = 0;
   time dll_time = 0;

   // ==========================================
   // Free-running link clock
   always #CK_HALF ck = ~ck;
   assign o_ck = ck;
   assign o_pins = pins;

   // ==========================================
   // Command issue, one CK wide, centred on a rise
   task automatic send(input sdmr_pins_t p);
      @(negedge ck);
      pins <= p;
      @(posedge ck);
      cmd_time = $time;
      @(negedge ck);
      // Deselect; flipped lines so stale levels never look valid
      pins <= {1'b1, ~p[19:0]};
   endtask

   task automatic mrs(input logic [2:0] ba, input logic [13:0] a);
      logic [13:0] v;
      v = a;
      v[13] = 1'b0;
      if (ba[0]) begin
         v[10:8] = {1'b0, v[9], 1'b0};
         v[11] = 1'b0;
      end
      if (!ba[0]) v[MR0_TM] = 1'b0;
      if (!ba[0] && v[11:9] < WR_MIN_CODE) v[11:9] = WR_MIN_CODE;
      if (ba[0] && !v[MR1_QOFF]) v[9] = 1'b0;
      send({4'h0, ba, v});
      if (!ba[0] && v[MR0_DLLR]) dll_time = cmd_time;
   endtask

   task automatic rw(input logic wr, input logic [13:0] a);
      while (!wr && $time < dll_time + DLL_LOCK_CK * 2 * CK_HALF)
         @(posedge ck);
      // chop select rides on the command
      send({1'b0, 1'b1, 1'b0, !wr, 3'h0, a});
   endtask
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
module tb;
   import sdmr_pkg::*;
   // ==========================================
   // Clock, reset and wiring
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic ck;
   sdmr_pins_t pins;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic pready, pslverr, dq_oe, rd_beat, wr_beat, wr_start;
   logic dll_reset, freeze;
   logic [31:0] prdata, rd;
   logic [2:0] beat_col;
   logic err;
   logic [2:0] cols[$];
   time tbeat[$];
   logic qoff = 1'b0;
   time t_wr = 0;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   int oe_cyc = 0;
   int dll_seen = 0;
   always #20 i_clock = ~i_clock;

   sdmr_ctrl_model model_i (.o_ck(ck), .o_pins(pins));
   sdmr_core #(.CWL(5), .TRP_CK(5)) sdmr_core_i (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_ck(ck), .i_pins(pins),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .o_dq_dqs_oe(dq_oe),
      .o_rd_beat(rd_beat), .o_wr_beat(wr_beat), .o_beat_col(beat_col),
      .o_wr_start(wr_start), .o_dll_reset(dll_reset),
      .o_dll_freeze_pd(freeze));

   // ==========================================
   // Monitor and hang guard
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (dq_oe === 1'b1) oe_cyc <= oe_cyc + 1;
      if (dll_reset === 1'b1) dll_seen <= dll_seen + 1;
      if (rd_beat === 1'b1 || wr_beat === 1'b1) begin
         cols.push_back(beat_col);
         tbeat.push_back($time);
      end
      if (wr_start === 1'b1) t_wr <= $time;
      if (cycles == 30000) begin
         fail_count++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // ==========================================
   // APB master
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      @(posedge i_clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge i_clock);
      penable <= 1'b1;
      // Only the run's own timeout ends this wait
      do begin
         @(posedge i_clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      check("register", rd, exp);
      check("slverr", 32'(err), 32'h00000000);
   endtask

   // ==========================================
   // Burst driver and expected column order
   function automatic logic [2:0] exp_col(input logic [2:0] s,
      input logic [2:0] b, input logic ilv, input logic wr, input logic chp);
      if (wr) return chp ? {s[2], b[1:0]} : b;
      if (ilv) return s ^ b;
      return {s[2] ^ b[2], s[1:0] + b[1:0]};
   endfunction

   task automatic burst(input logic wr, input logic [13:0] a,
      input logic ilv, input logic chp, input int n, input int lat);
      int b0;
      int o0;
      // Monitor owns the queues; only mark where this burst starts
      b0 = cols.size();
      o0 = oe_cyc;
      model_i.rw(wr, a);
      // Whole burst fits in 24 CK even at the longest delay used
      repeat (192) @(posedge i_clock);
      check("beats", cols.size() - b0, n);
      for (int k = b0; k < cols.size(); k++) check("col", cols[k],
         exp_col(a[2:0], 3'(k - b0), ilv, wr, chp));
      check("oe", (oe_cyc - o0 + 4) >> 3, (wr || qoff) ? 0 : n / 2);
      if (n > 0) check("latency", 32'(((wr ? t_wr : tbeat[b0])
         - model_i.cmd_time) / 320), lat);
   endtask

   // ==========================================
   // Test sequence
   initial begin
      repeat (6) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_clock);
      rdchk(ADDR_CTRL, 32'h00000001);
      rdchk(ADDR_MR0, 32'h00000000);
      rdchk(ADDR_STAT, 32'h00040A04);
      check("freeze", 32'(freeze), 32'h00000001);
      apb(1'b0, 12'h010, 32'h00000000);
      check("unmapped err", 32'(err), 32'h00000001);
      check("unmapped data", rd, 32'h00000000);
      apb(1'b1, ADDR_MR0, 32'hFFFFFFFF);
      rdchk(ADDR_MR0, 32'h00000000);
      // CL 7, WR 7, DLL reset, fast exit
      model_i.mrs(3'h0, 14'h1530);
      repeat (8) @(posedge i_clock);
      rdchk(ADDR_MR0, 32'h00001530);
      rdchk(ADDR_STAT, 32'h00010C07);
      repeat (160) @(posedge i_clock);
      rdchk(ADDR_MR0, 32'h00001430);
      rdchk(ADDR_STAT, 32'h00000C07);
      check("dll pulse", dll_seen, 1);
      check("freeze", 32'(freeze), 32'h00000000);
      for (int t = 0; t < 2; t++) begin
         model_i.mrs(3'h0, t[0] ? 14'h1438 : 14'h1430);
         for (int s = 0; s < 8; s++) begin
            burst(1'b0, {11'h000, 3'(s)}, t[0], 1'b0, 8, 7);
         end
         model_i.mrs(3'h0, t[0] ? 14'h143A : 14'h1432);
         burst(1'b0, 14'h0007, t[0], 1'b1, 4, 7);
      end
      burst(1'b1, 14'h0007, 1'b1, 1'b1, 4, 7);
      model_i.mrs(3'h0, 14'h1431);
      burst(1'b1, 14'h1003, 1'b0, 1'b1, 4, 9);
      burst(1'b1, 14'h0006, 1'b0, 1'b0, 8, 9);
      burst(1'b0, 14'h1001, 1'b0, 1'b0, 4, 7);
      burst(1'b0, 14'h0001, 1'b0, 1'b0, 8, 7);
      model_i.mrs(3'h1, 14'h0008);
      repeat (8) @(posedge i_clock);
      rdchk(ADDR_MR1, 32'h00000008);
      rdchk(ADDR_STAT, 32'h00000C0D);
      burst(1'b0, 14'h0002, 1'b0, 1'b0, 8, 13);
      // Outputs off and the shorter additive delay
      model_i.mrs(3'h1, 14'h1010);
      qoff = 1'b1;
      repeat (8) @(posedge i_clock);
      rdchk(ADDR_STAT, 32'h00000C0C);
      burst(1'b0, 14'h0003, 1'b0, 1'b0, 8, 12);
      model_i.mrs(3'h2, 14'h3FFF);
      repeat (8) @(posedge i_clock);
      rdchk(ADDR_MR0, 32'h00001431);
      rdchk(ADDR_MR1, 32'h00001010);
      apb(1'b1, ADDR_CTRL, 32'h00000000);
      rdchk(ADDR_CTRL, 32'h00000000);
      burst(1'b0, 14'h0000, 1'b0, 1'b0, 0, 0);
      complete_run();
   end
endmodule
